// ### pfe_cfg.svh
/*
 * Constants of the front-end serial load block: frame geometry, register
 * addresses, field positions and reset values.
 * Assumes it is included by bare name, before the package and the modules.
 */

`ifndef PFE_CFG_SVH
`define PFE_CFG_SVH

// ====================================================================
// Frame geometry
// ====================================================================
`define PFE_DAC_BITS 10
`define PFE_FRAME_BITS 16
`define PFE_ADDR_BITS 8
`define PFE_DATA_BITS 8

// ====================================================================
// Register addresses carried in the upper byte of a register frame
// ====================================================================
`define PFE_ADDR_FIRST_ENABLE 8'h01
`define PFE_ADDR_FIRST_CONTROL 8'h02
`define PFE_ADDR_RX_GAIN 8'h03

// ====================================================================
// Field positions
// ====================================================================
`define PFE_BAND_SELECT_BIT 3
`define PFE_DAC_MODE_BIT 5
`define PFE_IN_GAIN_LSB 0
`define PFE_OUT_GAIN_LSB 2

// ====================================================================
// Reset values
// ====================================================================
`define PFE_FIRST_ENABLE_RST 8'h00
`define PFE_FIRST_CONTROL_RST 8'h00
`define PFE_RX_GAIN_RST 8'h00
`define PFE_DAC_RST 10'h000

`endif

// ### pfe_host_model.sv
/*
 * Behavioural host serial port that loads the front-end block.
 * Assumes the bench calls frame() from a single process and leaves a gap
 * of several core cycles between frames.
 */

`timescale 1ns/10ps

module pfe_host_model (
    // Serial pins towards the device.
    output logic sclk_o,
    output logic cs_n_o,
    output logic din_o,
    output logic dac_sel_o
);
    // ================================================================
    // Idle pins
    // ================================================================
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        din_o = 1'b0;
        dac_sel_o = 1'b0;
    end

    // ================================================================
    // Frame transfer
    // ================================================================
    // The link clock runs only inside a frame, with a 160 ns period.
    // Data changes on the falling edge, so it is steady at the rising edge.
    task automatic frame(input logic sel, input logic [15:0] word, input int nbits);
        cs_n_o = 1'b0;
        #17.3;
        dac_sel_o = sel;
        #17.3;
        for (int i = 0; i < nbits; i++) begin
            din_o = word[15-i];
            #80;
            sclk_o = 1'b1;
            #80;
            sclk_o = 1'b0;
        end
        #40;
        cs_n_o = 1'b1;
        // A released data line must not keep showing the last bit.
        din_o = ~din_o;
    endtask
endmodule

// ### pfe_link_shift.sv
/*
 * Link-side shifter of the front-end serial load block, clocked by the host
 * serial clock.
 * Assumes the host changes data and frame pins away from the rising edge of
 * the serial clock, and that the clock stands still while chip select is high.
 */

`timescale 1ns/10ps

`include "pfe_cfg.svh"

module pfe_link_shift
    import pfe_pkg::*;
#(
    parameter int DAC_BITS = `PFE_DAC_BITS,
    parameter int FRAME_BITS = `PFE_FRAME_BITS
) (
    // Link clock, reset and frame pins.
    input wire logic sclk_i,
    input wire logic nrst_i,
    input wire logic cs_n_i,
    input wire logic din_i,
    input wire logic dac_sel_i,
    // Held frame, quasi-static while chip select is high.
    output logic [FRAME_BITS-1:0] word_o,
    output logic dac_frame_o,
    output logic full_o
);

    localparam int CW = $clog2(FRAME_BITS + 1);

    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] cnt_next;
    logic [FRAME_BITS-1:0] shift_reg;
    logic [FRAME_BITS-1:0] shift_next;
    logic dac_frame_reg;
    logic dac_frame_next;
    logic full_reg;
    logic full_next;

    // ================================================================
    // Bit steering
    // ================================================================
    // The frame kind is taken from the select pin at the first bit.
    wire first_bit = (cnt_reg == '0);
    wire dac_now = first_bit ? dac_sel_i : dac_frame_reg;
    wire [CW-1:0] limit = dac_now ? CW'(DAC_BITS) : CW'(FRAME_BITS);
    wire shifting = !cs_n_i && (cnt_reg < limit);

    assign cnt_next = shifting ? cnt_reg + CW'(1) : cnt_reg;
    assign shift_next = shifting ? {shift_reg[FRAME_BITS-2:0], din_i} : shift_reg;
    assign dac_frame_next = cs_n_i ? dac_frame_reg : dac_now;
    assign full_next = cs_n_i ? full_reg : (cnt_next == limit);

    // ================================================================
    // Registers
    // ================================================================
    // The bit count restarts whenever chip select is high, so each frame
    // begins at bit zero without needing a clock edge outside the frame.
    always_ff @(posedge sclk_i or negedge nrst_i or posedge cs_n_i) begin
        if (!nrst_i) begin
            cnt_reg <= '0;
        end else if (cs_n_i) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    always_ff @(posedge sclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            shift_reg <= '0;
            dac_frame_reg <= 1'b0;
            full_reg <= 1'b0;
        end else begin
            shift_reg <= shift_next;
            dac_frame_reg <= dac_frame_next;
            full_reg <= full_next;
        end
    end

    assign word_o = shift_reg;
    assign dac_frame_o = dac_frame_reg;
    assign full_o = full_reg;

    // ================================================================
    // Checks
    // ================================================================
    chk_trunc_extra_bits: assert property (
        @(posedge sclk_i) disable iff (!nrst_i)
        (!cs_n_i && dac_frame_reg && cnt_reg >= CW'(DAC_BITS))
        ##1 (!cs_n_i && cnt_reg != '0) |-> $stable(shift_reg))
        else $error("Converter frame kept bits past the word width.");

    chk_msb_first_shift: assert property (
        @(posedge sclk_i) disable iff (!nrst_i)
        shifting |=> (shift_reg[0] == $past(din_i)))
        else $error("Serial bit not shifted in at the low end.");

    chk_dac_route_select: assert property (
        @(posedge sclk_i) disable iff (!nrst_i)
        (!cs_n_i && first_bit) |=> (dac_frame_reg == $past(dac_sel_i)))
        else $error("Frame kind does not follow the select pin.");

    chk_dac_word_full: assert property (
        @(posedge sclk_i) disable iff (!nrst_i)
        (!cs_n_i && !first_bit && dac_frame_reg && cnt_reg == CW'(DAC_BITS - 1))
        |=> full_reg)
        else $error("Converter frame not marked full at its last bit.");

endmodule

// ### pfe_pkg.sv
/*
 * Types of the front-end serial load block: gain step encodings and the
 * register byte.
 * Assumes pfe_cfg.svh is compiled alongside; holds no logic.
 */

package pfe_pkg;

    // ================================================================
    // Gain steps
    // ================================================================
    // Input stage: quarter, half, unity and double gain, in code order.
    typedef enum logic [1:0] {
        PFE_IN_GAIN_QUARTER,
        PFE_IN_GAIN_HALF,
        PFE_IN_GAIN_UNITY,
        PFE_IN_GAIN_DOUBLE
    } pfe_in_gain_e;

    // Output stage: gains of 1, 4, 16 and 64, in code order.
    typedef enum logic [1:0] {
        PFE_OUT_GAIN_X1,
        PFE_OUT_GAIN_X4,
        PFE_OUT_GAIN_X16,
        PFE_OUT_GAIN_X64
    } pfe_out_gain_e;

    typedef logic [7:0] pfe_byte_t;

endpackage

// ### pfe_serial_load.sv
/*
 * Digital side of a powerline front-end: loads the 10-bit transmit converter
 * over the four-wire serial port and holds the receive gain and band settings.
 * Assumes a host that clocks data in on the rising serial clock edge, MSB
 * first, and leaves chip select high for at least four core clocks between
 * frames.
 */

// Operation
// - Input gain stage: four steps, quarter to double.
// - Output gain stage: gains 1, 4, 16, 64.
// - Band select lives at control bit 3.
// - Band bit low narrow band, high combined.
// - Converter value is 10 bits, serial only.
// - Select pin high routes data to converter.
// - Keep first 10 converter bits, drop rest.
// - Chip select rising updates converter output.
// - Converter mode needs pin and enable bit 5.

`timescale 1ns/10ps

`include "pfe_cfg.svh"

module pfe_serial_load
    import pfe_pkg::*;
#(
    parameter int DAC_BITS = `PFE_DAC_BITS,
    parameter int FRAME_BITS = `PFE_FRAME_BITS
) (
    // Core clock and reset.
    input wire logic CORE_CLK_I,
    input wire logic NRST_I,
    // Host serial port.
    input wire logic SCLK_I,
    input wire logic CS_N_I,
    input wire logic DIN_I,
    input wire logic DAC_SEL_I,
    // Transmit converter.
    output logic [DAC_BITS-1:0] DAC_VALUE_O,
    output logic DAC_UPDATE_O,
    output logic DAC_MODE_O,
    output logic PWM_MODE_O,
    // Receive chain settings.
    output pfe_in_gain_e RX_INPUT_GAIN_O,
    output pfe_out_gain_e RX_OUTPUT_GAIN_O,
    output logic BAND_SELECT_O,
    // Register contents and frame status.
    output pfe_byte_t FIRST_ENABLE_O,
    output pfe_byte_t FIRST_CONTROL_O,
    output logic SHORT_FRAME_O
);

    // ================================================================
    // Declarations
    // ================================================================
    logic [FRAME_BITS-1:0] link_word;
    logic link_dac_frame;
    logic link_full;

    logic cs_meta_reg;
    logic cs_mid_reg;
    logic cs_late_reg;
    logic cs_filt_reg;
    logic cs_filt_next;
    logic sel_meta_reg;
    logic sel_mid_reg;
    logic sel_late_reg;
    logic sel_filt_reg;
    logic sel_filt_next;

    pfe_byte_t first_enable_reg;
    pfe_byte_t first_enable_next;
    pfe_byte_t first_control_reg;
    pfe_byte_t first_control_next;
    pfe_byte_t rx_gain_reg;
    pfe_byte_t rx_gain_next;
    logic [DAC_BITS-1:0] dac_reg;
    logic [DAC_BITS-1:0] dac_next;
    logic update_reg;
    logic dac_mode_reg;
    logic dac_mode_next;
    logic pwm_mode_reg;
    logic pwm_mode_next;
    logic short_reg;
    logic short_next;

    // ================================================================
    // Link side
    // ================================================================
    // The shifter runs on the host serial clock; its outputs stand still
    // from the moment chip select rises until the next frame starts.
    pfe_link_shift #(
        .DAC_BITS(DAC_BITS),
        .FRAME_BITS(FRAME_BITS)
    ) u_link (
        .sclk_i(SCLK_I),
        .nrst_i(NRST_I),
        .cs_n_i(CS_N_I),
        .din_i(DIN_I),
        .dac_sel_i(DAC_SEL_I),
        .word_o(link_word),
        .dac_frame_o(link_dac_frame),
        .full_o(link_full)
    );

    // ================================================================
    // Pin synchronisers
    // ================================================================
    // Three stages per pin; a new level counts once the second and third
    // stages agree, which filters a single sampled glitch.
    assign cs_filt_next = (cs_mid_reg == cs_late_reg) ? cs_late_reg : cs_filt_reg;
    assign sel_filt_next = (sel_mid_reg == sel_late_reg) ? sel_late_reg : sel_filt_reg;

    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            cs_meta_reg <= 1'b1;
            cs_mid_reg <= 1'b1;
            cs_late_reg <= 1'b1;
            cs_filt_reg <= 1'b1;
        end else begin
            cs_meta_reg <= CS_N_I;
            cs_mid_reg <= cs_meta_reg;
            cs_late_reg <= cs_mid_reg;
            cs_filt_reg <= cs_filt_next;
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            sel_meta_reg <= 1'b0;
            sel_mid_reg <= 1'b0;
            sel_late_reg <= 1'b0;
            sel_filt_reg <= 1'b0;
        end else begin
            sel_meta_reg <= DAC_SEL_I;
            sel_mid_reg <= sel_meta_reg;
            sel_late_reg <= sel_mid_reg;
            sel_filt_reg <= sel_filt_next;
        end
    end

    // ================================================================
    // Frame decode
    // ================================================================
    // The end of a frame is the filtered rise of chip select; by then the
    // serial clock has stopped, so the held link word is safe to read.
    wire frame_end = cs_mid_reg && cs_late_reg && !cs_filt_reg;
    wire load_dac = frame_end && link_dac_frame && link_full;
    wire reg_write = frame_end && !link_dac_frame && link_full;
    wire [DAC_BITS-1:0] dac_word = link_word[DAC_BITS-1:0];
    wire [7:0] wr_addr = link_word[FRAME_BITS-1 -: 8];
    wire [7:0] wr_data = link_word[7:0];
    wire hit_first_enable = reg_write && (wr_addr == `PFE_ADDR_FIRST_ENABLE);
    wire hit_first_control = reg_write && (wr_addr == `PFE_ADDR_FIRST_CONTROL);
    wire hit_rx_gain = reg_write && (wr_addr == `PFE_ADDR_RX_GAIN);

    // ================================================================
    // Register file
    // ================================================================
    // Writes to any other address are ignored.
    assign first_enable_next = hit_first_enable ? wr_data : first_enable_reg;
    assign first_control_next = hit_first_control ? wr_data : first_control_reg;
    assign rx_gain_next = hit_rx_gain ? wr_data : rx_gain_reg;
    // The converter word changes only on a full converter frame.
    assign dac_next = load_dac ? dac_word : dac_reg;
    assign short_next = frame_end ? !link_full : short_reg;

    // Converter mode needs both the pin and the enable bit; both low picks
    // the pulse-width input, and a mismatch selects neither.
    assign dac_mode_next = sel_filt_reg && first_enable_reg[`PFE_DAC_MODE_BIT];
    assign pwm_mode_next = !sel_filt_reg && !first_enable_reg[`PFE_DAC_MODE_BIT];

    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            first_enable_reg <= `PFE_FIRST_ENABLE_RST;
            first_control_reg <= `PFE_FIRST_CONTROL_RST;
            rx_gain_reg <= `PFE_RX_GAIN_RST;
        end else begin
            first_enable_reg <= first_enable_next;
            first_control_reg <= first_control_next;
            rx_gain_reg <= rx_gain_next;
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            dac_reg <= `PFE_DAC_RST;
            update_reg <= 1'b0;
            short_reg <= 1'b0;
        end else begin
            dac_reg <= dac_next;
            update_reg <= load_dac;
            short_reg <= short_next;
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            dac_mode_reg <= 1'b0;
            pwm_mode_reg <= 1'b1;
        end else begin
            dac_mode_reg <= dac_mode_next;
            pwm_mode_reg <= pwm_mode_next;
        end
    end

    // ================================================================
    // Outputs
    // ================================================================
    assign DAC_VALUE_O = dac_reg;
    assign DAC_UPDATE_O = update_reg;
    assign DAC_MODE_O = dac_mode_reg;
    assign PWM_MODE_O = pwm_mode_reg;
    assign RX_INPUT_GAIN_O = pfe_in_gain_e'(rx_gain_reg[`PFE_IN_GAIN_LSB +: 2]);
    assign RX_OUTPUT_GAIN_O = pfe_out_gain_e'(rx_gain_reg[`PFE_OUT_GAIN_LSB +: 2]);
    // Low picks the narrow band cutoff, high the combined wider band.
    assign BAND_SELECT_O = first_control_reg[`PFE_BAND_SELECT_BIT];
    assign FIRST_ENABLE_O = first_enable_reg;
    assign FIRST_CONTROL_O = first_control_reg;
    assign SHORT_FRAME_O = short_reg;

    // ================================================================
    // Checks
    // ================================================================
    default clocking cb @(posedge CORE_CLK_I);
    endclocking

    default disable iff (!NRST_I);

    sequence s_dac_frame_done;
        frame_end && link_dac_frame && link_full;
    endsequence

    sequence s_control_write;
        reg_write && (wr_addr == `PFE_ADDR_FIRST_CONTROL);
    endsequence

    sequence s_gain_write;
        reg_write && (wr_addr == `PFE_ADDR_RX_GAIN);
    endsequence

    chk_dac_update_load: assert property (
        s_dac_frame_done |=> (DAC_VALUE_O == $past(dac_word)) && DAC_UPDATE_O
        ##1 !DAC_UPDATE_O)
        else $error("Converter not updated on the rise of chip select.");

    chk_dac_serial_only: assert property (
        !load_dac |=> $stable(DAC_VALUE_O) && !DAC_UPDATE_O)
        else $error("Converter value changed without a converter frame.");

    chk_dac_keep_value: assert property (
        (frame_end && !link_dac_frame) |=> $stable(DAC_VALUE_O) [*2])
        else $error("Register frame disturbed the converter value.");

    chk_band_select_write: assert property (
        s_control_write |=> (BAND_SELECT_O == $past(wr_data[`PFE_BAND_SELECT_BIT])))
        else $error("Band select does not follow control bit 3.");

    chk_in_gain_write: assert property (
        s_gain_write |=> (RX_INPUT_GAIN_O == pfe_in_gain_e'($past(wr_data[1:0]))))
        else $error("Input gain stage not set by its write.");

    chk_out_gain_write: assert property (
        s_gain_write |=> (RX_OUTPUT_GAIN_O == pfe_out_gain_e'($past(wr_data[3:2]))))
        else $error("Output gain stage not set by its write.");

    chk_dac_mode_pair: assert property (
        (sel_filt_reg && first_enable_reg[`PFE_DAC_MODE_BIT]) |=> DAC_MODE_O && !PWM_MODE_O)
        else $error("Converter mode not entered with pin and enable high.");

    chk_pwm_mode_pair: assert property (
        (!sel_filt_reg && !first_enable_reg[`PFE_DAC_MODE_BIT]) |=> PWM_MODE_O && !DAC_MODE_O)
        else $error("Pulse-width mode not entered with pin and enable low.");

    chk_mode_mismatch: assert property (
        (sel_filt_reg != first_enable_reg[`PFE_DAC_MODE_BIT]) |=> !DAC_MODE_O && !PWM_MODE_O)
        else $error("A mode was entered with pin and enable bit apart.");

    // A chip select rise seen by the first stage for three edges in a row
    // must end the frame exactly when it reaches the third stage.
    chk_frame_end_delay: assert property (
        ($rose(cs_meta_reg) && !cs_filt_reg) ##1 cs_meta_reg [*2] |-> frame_end)
        else $error("Chip select rise not seen after the third stage.");

    chk_update_one_pulse: assert property (
        DAC_UPDATE_O |=> !DAC_UPDATE_O)
        else $error("Converter update pulse lasted more than one cycle.");

    chk_short_frame_flag: assert property (
        frame_end |=> (SHORT_FRAME_O == !$past(link_full)))
        else $error("Short frame flag does not match the frame length.");

    chk_enable_hold: assert property (
        !hit_first_enable |=> $stable(FIRST_ENABLE_O))
        else $error("Enable register changed without a write to it.");

    chk_control_hold: assert property (
        !hit_first_control |=> $stable(FIRST_CONTROL_O))
        else $error("Control register changed without a write to it.");

    chk_gain_hold: assert property (
        !hit_rx_gain |=> $stable(RX_INPUT_GAIN_O) && $stable(RX_OUTPUT_GAIN_O))
        else $error("Gain stages changed without a write to them.");

endmodule

// ### pfe_serial_load_tb.sv
/*
 * Self-checking bench of the front-end serial load block.
 * Assumes the design files and pfe_host_model are compiled before it.
 */

`timescale 1ns/10ps

module pfe_serial_load_tb
    import pfe_pkg::*;
;
    logic core_clk;
    logic nrst_n;
    logic sclk, cs_n, din, dac_sel;
    logic [9:0] dac_value;
    logic dac_update, dac_mode, pwm_mode, band, short_frame;
    pfe_in_gain_e in_gain;
    pfe_out_gain_e out_gain;
    pfe_byte_t first_enable, first_control;
    int failures;
    int tests_run;
    logic [9:0] dac_exp;

    // ================================================================
    // Design and host
    // ================================================================
    pfe_host_model i_host (
        .sclk_o(sclk), .cs_n_o(cs_n), .din_o(din), .dac_sel_o(dac_sel)
    );

    pfe_serial_load i_dut (
        .CORE_CLK_I(core_clk), .NRST_I(nrst_n), .SCLK_I(sclk), .CS_N_I(cs_n),
        .DIN_I(din), .DAC_SEL_I(dac_sel), .DAC_VALUE_O(dac_value),
        .DAC_UPDATE_O(dac_update), .DAC_MODE_O(dac_mode), .PWM_MODE_O(pwm_mode),
        .RX_INPUT_GAIN_O(in_gain), .RX_OUTPUT_GAIN_O(out_gain),
        .BAND_SELECT_O(band), .FIRST_ENABLE_O(first_enable), .FIRST_CONTROL_O(first_control),
        .SHORT_FRAME_O(short_frame)
    );

    always #2 core_clk = ~core_clk;

    // ================================================================
    // Tasks
    // ================================================================
    task automatic results();
        if (failures == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("ERROR at %0t ns: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic reg_wr(input logic [7:0] addr, input logic [7:0] data, input int nbits);
        @(posedge core_clk);
        #1;
        i_host.frame(1'b0, {addr, data}, nbits);
        repeat (10) @(posedge core_clk);
        #1;
        check(16'(dac_value), 16'(dac_exp));
        check(16'(short_frame), 16'(nbits < 16));
    endtask

    task automatic dac_wr(input logic [15:0] word, input int nbits);
        int k;
        @(posedge core_clk);
        #1;
        i_host.frame(1'b1, word, nbits);
        check(16'(dac_value), 16'(dac_exp));
        if (nbits >= 10) begin
            dac_exp = word[15:6];
        end
        k = 0;
        while (k < 20 && dac_update !== 1'b1) begin
            @(posedge core_clk);
            #1;
            k++;
        end
        check(16'(dac_update), 16'(nbits >= 10));
        check(16'(dac_value), 16'(dac_exp));
        if (nbits >= 10) begin
            @(posedge core_clk);
            #1;
            check(16'(dac_update), 16'h0000);
        end
        check(16'(short_frame), 16'(nbits < 10));
        repeat (4) @(posedge core_clk);
        #1;
    endtask

    // ================================================================
    // Watchdog
    // ================================================================
    initial begin
        #200000;
        failures++;
        results();
    end

    // ================================================================
    // Test sequence
    // ================================================================
    initial begin
        core_clk = 1'b0;
        nrst_n = 1'b0;
        failures = 0;
        tests_run = 0;
        dac_exp = 10'h000;
        repeat (5) @(posedge core_clk);
        #1;
        check(16'(dac_value), 16'h0000);
        check({15'h0000, pwm_mode}, 16'h0001);
        check({15'h0000, dac_mode}, 16'h0000);
        check({8'h00, first_enable}, 16'h0000);
        check({8'h00, first_control}, 16'h0000);
        check({14'h0000, in_gain, out_gain}, 16'h0000);
        @(posedge core_clk);
        #1;
        nrst_n = 1'b1;
        repeat (6) @(posedge core_clk);
        // Converter frames: truncation, exact length, short, LSB only.
        dac_wr(16'hA97F, 16);
        dac_wr(16'hFFC0, 10);
        dac_wr(16'h5500, 9);
        dac_wr(16'h0040, 12);
        // Select pin high with the enable bit clear selects neither mode.
        check({14'h0000, dac_mode, pwm_mode}, 16'h0000);
        reg_wr(8'h01, 8'h20, 16);
        check({8'h00, first_enable}, 16'h0020);
        check({14'h0000, dac_mode, pwm_mode}, 16'h0000);
        dac_wr(16'h1234, 10);
        check({14'h0000, dac_mode, pwm_mode}, 16'h0002);
        reg_wr(8'h01, 8'h00, 16);
        check({14'h0000, dac_mode, pwm_mode}, 16'h0001);
        // Band select in both states.
        reg_wr(8'h02, 8'h08, 16);
        check({8'h00, first_control}, 16'h0008);
        check({15'h0000, band}, 16'h0001);
        reg_wr(8'h02, 8'hF7, 16);
        check({15'h0000, band}, 16'h0000);
        // A short register frame and an unknown address change nothing.
        reg_wr(8'h02, 8'h08, 12);
        check({8'h00, first_control}, 16'h00F7);
        reg_wr(8'h7F, 8'hFF, 16);
        check({8'h00, first_control}, 16'h00F7);
        check({8'h00, first_enable}, 16'h0000);
        // Every gain step of both stages.
        for (int i = 0; i < 4; i++) begin
            reg_wr(8'h03, 8'(((3 - i) << 2) | i), 16);
            check(16'(in_gain), 16'(i));
            check(16'(out_gain), 16'(3 - i));
        end
        dac_wr(16'h3FC0, 16);
        results();
    end
endmodule
